// file: rtl/strap_sample_pin_function.v
// Shared configuration and status pin logic of the hub: strap capture at reset
// release, serial pin ownership, port power control and status pin drive.
// Assumes pins are asynchronous to clock and reset is the chip reset.
//
// What this block does
// (R01) Low on port 4 over-current input means over-current; high means none.
// (R02) Sample interface select at reset release: 1 picks I2C, 0 SMBus.
// (R03) In I2C mode the serial pins belong to the EEPROM master.
// (R04) In SMBus mode the serial pins belong to the slave, driven by the host.
// (R05) After reset, if enabled, drive interface select pin high while link suspended.
// (R06) Sample power strap at release: 0 enables switching and over-current, 1 disables.
// (R07) With power management on, each port power output controls that port.
// (R08) In SMBus mode slave address bit 1 comes from the power strap.
// (R09) After reset, if enabled, drive power strap pin high while SuperSpeed connected.
// (R10) Boards using battery charging must strap power switching enabled.
// (R11) Sample polarity strap at release: 0 outputs active low, 1 active high.
// (R12) Sample each power control pin at release as its charge support bit.
// (R13) In SMBus mode slave address bit 2 comes from the ganged strap.
// (R14) Hold straps until next reset; drive status pins only after capture.
`timescale 1ns/10ps
`default_nettype none
`include "strap_pins_defs.vh"
module strap_sample_pin_function (
	input  wire       clock,
	input  wire       rst,
	// Strap and shared pin inputs
	input  wire       host_if_select_in,
	input  wire       power_mgmt_disable_strap_in,
	input  wire       power_ctrl_polarity_in,
	input  wire       ganged_strap_in,
	input  wire [3:0] port_power_ctrl_in,
	input  wire       port4_overcurrent_n,
	input  wire [3:0] port_overcurrent_n_lo,
	// Shared pin drive
	output reg        host_if_select_out,
	output wire       host_if_select_oe,
	output reg        power_mgmt_disable_strap_out,
	output wire       power_mgmt_disable_strap_oe,
	output reg  [3:0] port_power_ctrl,
	output wire [3:0] port_power_ctrl_oe,
	// Serial pins (clock and data) from both internal owners
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       scl_oe,
	output wire       sda_oe,
	input  wire       eeprom_scl_oe,
	input  wire       eeprom_sda_oe,
	input  wire       slave_scl_oe,
	input  wire       slave_sda_oe,
	output wire       eeprom_scl_in,
	output wire       eeprom_sda_in,
	output wire       slave_scl_in,
	output wire       slave_sda_in,
	// Core-side control and status
	input  wire [3:0] port_power_on,
	input  wire       suspend_status_enable,
	input  wire       ss_connect_status_enable,
	input  wire       upstream_ss_suspended,
	input  wire       upstream_ss_connected,
	output reg        i2c_mode,
	output reg        power_mgmt_enabled,
	output reg        power_ctrl_active_high,
	output reg  [3:0] charge_support_strap,
	output reg        slave_addr_bit1,
	output reg        slave_addr_bit2,
	output reg  [3:0] port_overcurrent,
	output reg        straps_valid
);
	localparam [2:0] ST_SAMPLE  = `ST_SAMPLE;
	localparam [2:0] ST_CAPTURE = `ST_CAPTURE;
	localparam [2:0] ST_RUN     = `ST_RUN;

	reg  [2:0] state;
	reg  [2:0] next_state;
	wire       sel_sync;
	wire       pm_sync;
	wire       pol_sync;
	wire       gang_sync;
	wire [3:0] pwr_sync;
	wire [3:0] oc_sync;
	wire [3:0] oc_raw;

	assign oc_raw = {port4_overcurrent_n, port_overcurrent_n_lo[2:0]};

	// Synchronisers for every strap and over-current pin input; the serial pins are not synchronised
	pin_sync #(.RESET_VALUE(1'b1)) u_sel  (.clock(clock), .rst(rst), .pin(host_if_select_in),           .level(sel_sync));
	pin_sync #(.RESET_VALUE(1'b0)) u_pm   (.clock(clock), .rst(rst), .pin(power_mgmt_disable_strap_in), .level(pm_sync));
	pin_sync #(.RESET_VALUE(1'b1)) u_pol  (.clock(clock), .rst(rst), .pin(power_ctrl_polarity_in),      .level(pol_sync));
	pin_sync #(.RESET_VALUE(1'b0)) u_gang (.clock(clock), .rst(rst), .pin(ganged_strap_in),             .level(gang_sync));

	genvar g;
	generate
		for (g = 0; g < `NUM_PORTS; g = g + 1) begin : g_port
			pin_sync #(.RESET_VALUE(1'b0)) u_pwr (.clock(clock), .rst(rst), .pin(port_power_ctrl_in[g]), .level(pwr_sync[g]));
			pin_sync #(.RESET_VALUE(1'b1)) u_oc  (.clock(clock), .rst(rst), .pin(oc_raw[g]),             .level(oc_sync[g]));
		end
	endgenerate

	// Sequencer: wait for synchronisers to fill after release, capture once, then run
	always @* begin
		next_state = state;
		case (state)
			ST_SAMPLE:  next_state = ST_CAPTURE;
			ST_CAPTURE: next_state = ST_RUN;
			ST_RUN:     next_state = ST_RUN;
			default:    next_state = ST_SAMPLE;
		endcase
	end

	// Capture counter lets the three-stage pipeline fill before sampling
	reg [1:0] fill_count;
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			state      <= ST_SAMPLE;
			fill_count <= 2'h0;
		end else if (state == ST_SAMPLE && fill_count != `FILL_LAST) begin
			fill_count <= fill_count + 2'h1;
		end else begin
			state <= next_state;
		end
	end

	// Strap latches, written only at capture and held until next reset
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			i2c_mode               <= `SEL_I2C;
			power_mgmt_enabled     <= 1'b0;
			power_ctrl_active_high <= `POL_ACTIVE_HIGH;
			charge_support_strap   <= 4'h0;
			slave_addr_bit1        <= 1'b0;
			slave_addr_bit2        <= 1'b0;
			straps_valid           <= 1'b0;
		end else if (state == ST_CAPTURE) begin // R14
			i2c_mode               <= (sel_sync == `SEL_I2C); // R02
			power_mgmt_enabled     <= (pm_sync == `PM_ENABLED); // R06
			power_ctrl_active_high <= (pol_sync == `POL_ACTIVE_HIGH); // R11
			charge_support_strap   <= pwr_sync; // R12
			slave_addr_bit1        <= (sel_sync == `SEL_SMBUS) ? pm_sync : 1'b0; // R08
			slave_addr_bit2        <= (sel_sync == `SEL_SMBUS) ? gang_sync : 1'b0; // R13
			straps_valid           <= 1'b1;
		end
	end

	// Over-current flags; ignored while power management is disabled
	always @(posedge clock or posedge rst) begin
		if (rst)
			port_overcurrent <= 4'h0;
		else if (straps_valid && power_mgmt_enabled)
			port_overcurrent <= ~oc_sync; // R01
		else
			port_overcurrent <= 4'h0;
	end

	// Port power outputs follow the captured polarity
	always @(posedge clock or posedge rst) begin
		if (rst)
			port_power_ctrl <= 4'h0;
		else if (power_ctrl_active_high)
			port_power_ctrl <= port_power_on & {4{power_mgmt_enabled}}; // R07
		else
			port_power_ctrl <= ~(port_power_on & {4{power_mgmt_enabled}}); // R07
	end

	assign port_power_ctrl_oe = {4{straps_valid & power_mgmt_enabled}}; // R07 R14

	// Status drive on the strap pins once straps are held
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			host_if_select_out           <= 1'b0;
			power_mgmt_disable_strap_out <= 1'b0;
		end else begin
			host_if_select_out           <= upstream_ss_suspended; // R05
			power_mgmt_disable_strap_out <= upstream_ss_connected; // R09
		end
	end

	assign host_if_select_oe           = straps_valid & suspend_status_enable; // R05 R14
	assign power_mgmt_disable_strap_oe = straps_valid & ss_connect_status_enable; // R09 R14

	// Serial pin ownership by captured mode; open-drain pull low only
	assign scl_oe        = straps_valid & (i2c_mode ? eeprom_scl_oe : slave_scl_oe); // R03 R04
	assign sda_oe        = straps_valid & (i2c_mode ? eeprom_sda_oe : slave_sda_oe); // R03 R04
	assign eeprom_scl_in = i2c_mode ? scl_in : 1'b1; // R03
	assign eeprom_sda_in = i2c_mode ? sda_in : 1'b1; // R03
	assign slave_scl_in  = i2c_mode ? 1'b1 : scl_in; // R04
	assign slave_sda_in  = i2c_mode ? 1'b1 : sda_in; // R04
endmodule
`default_nettype wire

// file: rtl/strap_pins_defs.vh
// Constants for the shared strap and status pin logic.
// Assumes inclusion by bare name from rtl files.
`ifndef STRAP_PINS_DEFS_VH
`define STRAP_PINS_DEFS_VH
`define NUM_PORTS        4
`define SEL_I2C          1'h1
`define SEL_SMBUS        1'h0
`define PM_ENABLED       1'h0
`define POL_ACTIVE_HIGH  1'h1
`define OC_ACTIVE        1'h0
`define SYNC_STAGES      3
`define FILL_LAST        2'h3
`define ST_SAMPLE        3'h1
`define ST_CAPTURE       3'h2
`define ST_RUN           3'h4
`define ADDR_BIT1        1
`define ADDR_BIT2        2
`endif

// file: rtl/pin_sync.v
// Three-stage synchroniser for one asynchronous pin input.
// Assumes a single clock domain and an asynchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter RESET_VALUE = 1'b0
) (
	input  wire clock,
	input  wire rst,
	input  wire pin,
	output reg  level
);
	reg stage1;
	reg stage2;
	reg stage3;

	// Stage one feeds only stage two; level changes once stages two and three agree
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			stage1 <= RESET_VALUE;
			stage2 <= RESET_VALUE;
			stage3 <= RESET_VALUE;
			level  <= RESET_VALUE;
		end else begin
			stage1 <= pin;
			stage2 <= stage1;
			stage3 <= stage2;
			if (stage2 == stage3)
				level <= stage3;
		end
	end
endmodule
`default_nettype wire

// file: bench/strap_pins_checker.sv
// Checker for the strap capture and shared pin logic.
// Assumes one clock domain and the top module's port names.
`timescale 1ns/10ps
`default_nettype none
module strap_pins_checker (
	input wire logic       clock, rst, straps_valid, i2c_mode, power_mgmt_enabled, power_ctrl_active_high,
	input wire logic       port4_overcurrent_n, host_if_select_out, host_if_select_oe,
	input wire logic       power_mgmt_disable_strap_out, power_mgmt_disable_strap_oe,
	input wire logic       suspend_status_enable, ss_connect_status_enable, upstream_ss_suspended,
	input wire logic       upstream_ss_connected, scl_oe, sda_oe, eeprom_scl_oe, eeprom_sda_oe,
	input wire logic       slave_scl_oe, slave_sda_oe,
	input wire logic [3:0] port_power_ctrl, port_power_ctrl_oe, port_power_on, port_overcurrent
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// Shared pin drive and captured straps
	oe_gate_a: assert property (!straps_valid |-> !host_if_select_oe && !power_mgmt_disable_strap_oe)
		else $error("status pin driven before capture");
	hold_a: assert property (straps_valid |=> straps_valid && $stable({i2c_mode, power_mgmt_enabled}))
		else $error("captured strap changed");
	sel_a: assert property (straps_valid && suspend_status_enable |=> host_if_select_out == $past(upstream_ss_suspended))
		else $error("suspend status wrong");
	conn_a: assert property (straps_valid && ss_connect_status_enable |=> power_mgmt_disable_strap_out == $past(upstream_ss_connected))
		else $error("connect status wrong");
	pwr_a: assert property (straps_valid && power_mgmt_enabled |=> port_power_ctrl == (power_ctrl_active_high ? $past(port_power_on) : ~$past(port_power_on)))
		else $error("power output wrong");
	oc_off_a: assert property (straps_valid && !power_mgmt_enabled |-> port_overcurrent == 4'h0)
		else $error("over-current seen while disabled");
	oc4_a: assert property ((straps_valid && power_mgmt_enabled && !port4_overcurrent_n) [*6] |-> port_overcurrent[3])
		else $error("port 4 over-current missed");
	i2c_pins_a: assert property (straps_valid && i2c_mode |-> scl_oe == eeprom_scl_oe && sda_oe == eeprom_sda_oe)
		else $error("serial pins not with master");
	slave_pins_a: assert property (straps_valid && !i2c_mode |-> scl_oe == slave_scl_oe && sda_oe == slave_sda_oe)
		else $error("serial pins not with slave");
endmodule
bind strap_sample_pin_function strap_pins_checker i_strap_pins_checker (.*);
`default_nettype wire

// file: bench/far_side_model.sv
// Power switches with fault outputs and an SMBus host on the serial wires.
// Assumes open-drain serial pins with a board pull-up.
`timescale 1ns/10ps
`default_nettype none
module far_side_model (
	input wire logic [3:0] fault,
	input wire logic       scl_oe, sda_oe, host_pull,
	output logic     [3:0] oc_n,
	output logic           scl, sda
);
	// Fault pulls the switch flag low, else pulled up
	assign oc_n = ~fault;
	// Wired-and of device and host pull-downs
	assign scl = !(scl_oe | host_pull);
	assign sda = !(sda_oe | host_pull);
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the strap capture and shared pin logic.
// Assumes the design files and the far side model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clock, rst, host_if_select_in, power_mgmt_disable_strap_in, power_ctrl_polarity_in, ganged_strap_in;
	logic host_pull, suspend_status_enable, ss_connect_status_enable, upstream_ss_suspended, upstream_ss_connected;
	logic eeprom_scl_oe, eeprom_sda_oe, slave_scl_oe, slave_sda_oe, scl_in, sda_in, scl_oe, sda_oe;
	logic host_if_select_out, host_if_select_oe, power_mgmt_disable_strap_out, power_mgmt_disable_strap_oe;
	logic eeprom_scl_in, eeprom_sda_in, slave_scl_in, slave_sda_in, i2c_mode, power_mgmt_enabled;
	logic power_ctrl_active_high, slave_addr_bit1, slave_addr_bit2, straps_valid, port4_overcurrent_n;
	logic [3:0] port_power_ctrl_in, port_overcurrent_n_lo, port_power_ctrl, port_power_ctrl_oe, port_power_on;
	logic [3:0] charge_support_strap, port_overcurrent, fault, oc_n;
	int         fail_count = 0;
	int         checks_done = 0;
	strap_sample_pin_function i_strap_sample_pin_function (.*);
	far_side_model i_far_side_model (.fault(fault), .scl_oe(scl_oe), .sda_oe(sda_oe), .host_pull(host_pull),
		.oc_n(oc_n), .scl(scl_in), .sda(sda_in));
	assign port4_overcurrent_n = oc_n[3];
	assign port_overcurrent_n_lo = {1'h1, oc_n[2:0]};
	// Clock and watchdog
	initial begin
		clock = 1'h0;
		forever #25 clock = ~clock;
	end
	initial begin
		#200000;
		fail_count++;
		close_out();
	end
	task chk(input logic [3:0] got, input logic [3:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task close_out;
		if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task step(input int n);
		repeat (n) @(posedge clock);
		#5;
	endtask
	// Reset with straps, wait for capture, then move the straps away
	task boot(input logic [7:0] s);
		rst = 1'h1;
		fault = 4'h0;
		port_power_on = 4'h0;
		{host_if_select_in, power_mgmt_disable_strap_in, power_ctrl_polarity_in, ganged_strap_in, port_power_ctrl_in} = s;
		step(16);
		rst = 1'h0;
		for (int n = 0; n < 10 && straps_valid !== 1'h1; n++) step(1);
		chk(straps_valid, 4'h1);
		{host_if_select_in, power_mgmt_disable_strap_in, power_ctrl_polarity_in, ganged_strap_in, port_power_ctrl_in} = ~s;
		step(2);
	endtask
	// Main sequence
	initial begin
		{rst, host_pull, suspend_status_enable, ss_connect_status_enable, upstream_ss_suspended} = 5'h1;
		{upstream_ss_connected, eeprom_scl_oe, eeprom_sda_oe, slave_scl_oe, slave_sda_oe} = 5'h0;
		{fault, port_power_on, host_if_select_in, power_mgmt_disable_strap_in} = 10'h0;
		{power_ctrl_polarity_in, ganged_strap_in, port_power_ctrl_in} = 6'h0;
		boot(8'hBA);
		chk({i2c_mode, power_mgmt_enabled, power_ctrl_active_high}, 4'h7);
		chk(charge_support_strap, 4'hA);
		{suspend_status_enable, upstream_ss_suspended, ss_connect_status_enable, upstream_ss_connected} = 4'hF;
		{eeprom_scl_oe, slave_sda_oe} = 2'h3;
		port_power_on = 4'h9;
		step(2);
		chk(port_power_ctrl, 4'h9);
		chk(port_power_ctrl_oe, 4'hF);
		chk({scl_oe, sda_oe}, 4'h2);
		chk({host_if_select_oe, host_if_select_out}, 4'h3);
		chk({power_mgmt_disable_strap_oe, power_mgmt_disable_strap_out}, 4'h3);
		fault = 4'h8;
		step(6);
		chk(port_overcurrent, 4'h8);
		boot(8'h60);
		chk({i2c_mode, power_mgmt_enabled, slave_addr_bit2, slave_addr_bit1}, 4'h1);
		chk(port_power_ctrl_oe, 4'h0);
		fault = 4'hF;
		step(6);
		chk(port_overcurrent, 4'h0);
		chk({scl_oe, sda_oe}, 4'h1);
		boot(8'h13);
		chk({slave_addr_bit2, slave_addr_bit1}, 4'h2);
		port_power_on = 4'h3;
		host_pull = 1'h1;
		step(2);
		chk(port_power_ctrl, 4'hC);
		chk({eeprom_sda_in, slave_sda_in}, 4'h2);
		chk({eeprom_scl_in, slave_scl_in}, 4'h2);
		suspend_status_enable = 1'h0;
		step(1);
		chk({host_if_select_oe, power_mgmt_disable_strap_oe}, 4'h1);
		close_out();
	end
endmodule
`default_nettype wire
